//--- bpci_regs.svh
// register offsets, field positions and reset values for the byte port block
`ifndef BPCI_REGS_SVH
`define BPCI_REGS_SVH

`define BPCI_ADDR_PORT      4'h0
`define BPCI_ADDR_LATCH     4'h1
`define BPCI_ADDR_DIR       4'h2
`define BPCI_ADDR_ICTL1     4'h3
`define BPCI_ADDR_ICTL2     4'h4
`define BPCI_ADDR_ICTL3     4'h5
`define BPCI_ADDR_SEGEN1    4'h6
`define BPCI_ADDR_SEGEN3    4'h7
`define BPCI_ADDR_IRQ_STAT  4'h8
`define BPCI_ADDR_IRQ_MASK  4'h9

`define BPCI_ICTL1_FLAG_BIT   0
`define BPCI_ICTL1_ENABLE_BIT 3
`define BPCI_ICTL2_PUDIS_BIT  7
`define BPCI_ICTL2_PRIO_BIT   0

`define BPCI_SEG8_BIT   0
`define BPCI_SEG9_BIT   1
`define BPCI_SEG10_BIT  2
`define BPCI_SEG11_BIT  3
`define BPCI_SEG_TWENTY_NINE_BIT  5
`define BPCI_SEG_THIRTY_BIT       6

`define BPCI_RST_LATCH   8'h00
`define BPCI_RST_DIR     8'hff
`define BPCI_RST_ICTL1   8'h00
`define BPCI_RST_ICTL2   8'hff
`define BPCI_RST_ICTL3   8'hc0
`define BPCI_RST_SEGEN   8'h00

`endif

//--- bpci_pkg.sv
// types for the byte port block
package bpci_pkg;
   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] dir;
      logic [7:0] ictl1;
      logic [7:0] ictl2;
      logic [7:0] ictl3;
      logic [7:0] segen1;
      logic [7:0] segen3;
      logic [3:0] snap;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [7:0] rdata;
      logic       ack;
   } bpci_state_t;
endpackage : bpci_pkg

//--- bpci_port.sv
// eight-bit port with change detect, pull-up control, segment and debug overrides
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`include "bpci_regs.svh"
module bpci_port (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // classic wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // write qualifier from the core: destination write of a memory-to-memory move
   input  wire logic        mem_to_mem_move_i,
   // package pins
   input  wire logic [7:0]  pin_i,
   output logic      [7:0]  pin_o,
   output logic      [7:0]  pin_oe_o,
   output logic      [7:0]  pullup_en_o,
   // segment driver
   input  wire logic        lcd_seg_thirty_i,
   input  wire logic        lcd_seg_eight_i,
   input  wire logic        lcd_seg_nine_i,
   input  wire logic        lcd_seg_ten_i,
   input  wire logic        lcd_seg_eleven_i,
   input  wire logic        lcd_seg_twenty_nine_i,
   output logic      [5:0]  seg_sel_o,
   // debug engine
   input  wire logic        debug_mode_i,
   input  wire logic        debug_serial_data_i,
   input  wire logic        debug_serial_data_oe_i,
   output logic             debug_serial_clock_o,
   output logic             debug_serial_data_o,
   // interrupt side
   output logic      [3:0]  ext_irq_in_o,
   output logic             port_change_irq_o,
   output logic             port_change_priority_o,
   output logic             wake_o,
   output logic             irq_o
);

   bpci_pkg::bpci_state_t s_reg;
   bpci_pkg::bpci_state_t s_next;

   logic [5:0] seg_en;
   logic [5:0] seg_val;
   logic [3:0] mismatch;
   logic       any_mismatch;
   logic [7:0] port_rd;
   logic       req;
   logic       wr;
   logic       rd;
   logic [3:0] idx;
   logic       addr_ok;

   // byte-lane merge: only lane 0 carries the 8-bit registers
   function automatic logic [7:0] lane0(input logic [7:0] old_v, input logic [31:0] d, input logic [3:0] sel);
      lane0 = sel[0] ? d[7:0] : old_v;
   endfunction : lane0

   assign req     = wb_cyc_i & wb_stb_i & ~s_reg.ack;
   assign idx     = wb_adr_i[5:2];
   assign addr_ok = idx <= `BPCI_ADDR_IRQ_MASK;
   assign wr      = req & wb_we_i & wb_sel_i[0] & addr_ok;
   assign rd      = req & ~wb_we_i & addr_ok;

   // segment enables per pin, pin order 0..5
   assign seg_en  = {s_reg.segen3[`BPCI_SEG_TWENTY_NINE_BIT], s_reg.segen1[`BPCI_SEG11_BIT],
                     s_reg.segen1[`BPCI_SEG10_BIT], s_reg.segen1[`BPCI_SEG9_BIT],
                     s_reg.segen1[`BPCI_SEG8_BIT], s_reg.segen3[`BPCI_SEG_THIRTY_BIT]};
   assign seg_val = {lcd_seg_twenty_nine_i, lcd_seg_eleven_i, lcd_seg_ten_i,
                     lcd_seg_nine_i, lcd_seg_eight_i, lcd_seg_thirty_i};
   assign seg_sel_o = seg_en;

   // pin drive: segment first, then debug, then latch when direction is 0
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_low
         assign pin_o[g]    = seg_en[g] ? seg_val[g] : s_reg.latch[g];
         assign pin_oe_o[g] = seg_en[g] | ~s_reg.dir[g];
         // pull-up only on a port input with global enable; debug mode removes it from pins 6 and 7
         assign pullup_en_o[g] = ~s_reg.ictl2[`BPCI_ICTL2_PUDIS_BIT] & s_reg.dir[g] & ~seg_en[g];
      end
   endgenerate

   assign pin_o[6]    = s_reg.latch[6];
   assign pin_oe_o[6] = ~debug_mode_i & ~s_reg.dir[6];
   assign pin_o[7]    = debug_mode_i ? debug_serial_data_i : s_reg.latch[7];
   assign pin_oe_o[7] = debug_mode_i ? debug_serial_data_oe_i : ~s_reg.dir[7];
   assign pullup_en_o[7:6] = {2{~s_reg.ictl2[`BPCI_ICTL2_PUDIS_BIT]}} & s_reg.dir[7:6]
                             & {2{~debug_mode_i}};
   assign debug_serial_clock_o = debug_mode_i & pin_i[6];
   assign debug_serial_data_o  = debug_mode_i & pin_i[7];

   // external interrupt inputs only from input pins not claimed by segments
   assign ext_irq_in_o = pin_i[3:0] & s_reg.dir[3:0] & ~seg_en[3:0];

   // readback: output pins show their drive level, input pins the pad
   assign port_rd = (pin_i & s_reg.dir) | (pin_o & ~s_reg.dir);

   // upper-nibble compare; outputs and debug-owned pins never mismatch
   assign mismatch     = (pin_i[7:4] ^ s_reg.snap) & s_reg.dir[7:4]
                         & {~debug_mode_i, ~debug_mode_i, ~seg_en[5:4]};
   assign any_mismatch = |mismatch;

   assign port_change_irq_o      = s_reg.ictl1[`BPCI_ICTL1_FLAG_BIT] & s_reg.ictl1[`BPCI_ICTL1_ENABLE_BIT];
   assign port_change_priority_o = s_reg.ictl2[`BPCI_ICTL2_PRIO_BIT];
   assign wake_o                 = port_change_irq_o;
   assign irq_o                  = |(s_reg.irq_stat & s_reg.irq_mask);

   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = {24'h000000, s_reg.rdata};

   always_comb begin
      s_next     = s_reg;
      s_next.ack = req;
      if (rd) begin
         case (idx)
            `BPCI_ADDR_PORT:     s_next.rdata = port_rd;
            `BPCI_ADDR_LATCH:    s_next.rdata = s_reg.latch;
            `BPCI_ADDR_DIR:      s_next.rdata = s_reg.dir;
            `BPCI_ADDR_ICTL1:    s_next.rdata = s_reg.ictl1;
            `BPCI_ADDR_ICTL2:    s_next.rdata = s_reg.ictl2;
            `BPCI_ADDR_ICTL3:    s_next.rdata = s_reg.ictl3;
            `BPCI_ADDR_SEGEN1:   s_next.rdata = s_reg.segen1;
            `BPCI_ADDR_SEGEN3:   s_next.rdata = s_reg.segen3;
            `BPCI_ADDR_IRQ_STAT: s_next.rdata = {6'h00, s_reg.irq_stat};
            `BPCI_ADDR_IRQ_MASK: s_next.rdata = {6'h00, s_reg.irq_mask};
            default:             s_next.rdata = 8'h00;
         endcase
      end else if (req) begin
         s_next.rdata = 8'h00;
      end
      if (wr) begin
         case (idx)
            `BPCI_ADDR_PORT,
            `BPCI_ADDR_LATCH:    s_next.latch  = lane0(s_reg.latch, wb_dat_i, wb_sel_i);
            `BPCI_ADDR_DIR:      s_next.dir    = lane0(s_reg.dir, wb_dat_i, wb_sel_i);
            `BPCI_ADDR_ICTL1:    s_next.ictl1  = lane0(s_reg.ictl1, wb_dat_i, wb_sel_i);
            `BPCI_ADDR_ICTL2:    s_next.ictl2  = lane0(s_reg.ictl2, wb_dat_i, wb_sel_i);
            `BPCI_ADDR_ICTL3:    s_next.ictl3  = lane0(s_reg.ictl3, wb_dat_i, wb_sel_i);
            `BPCI_ADDR_SEGEN1:   s_next.segen1 = lane0(s_reg.segen1, wb_dat_i, wb_sel_i);
            `BPCI_ADDR_SEGEN3:   s_next.segen3 = lane0(s_reg.segen3, wb_dat_i, wb_sel_i);
            `BPCI_ADDR_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~wb_dat_i[1:0];
            `BPCI_ADDR_IRQ_MASK: s_next.irq_mask = wb_dat_i[1:0];
            default:             s_next.rdata  = s_reg.rdata;
         endcase
      end
      // any port access re-arms the snapshot, except a move destination write
      if ((rd | (wr & ~mem_to_mem_move_i)) && idx == `BPCI_ADDR_PORT) begin
         s_next.snap = pin_i[7:4];
      end
      // hardware set wins over a software clear in the same cycle
      if (any_mismatch) begin
         s_next.ictl1[`BPCI_ICTL1_FLAG_BIT] = 1'b1;
      end
      // sticky status: bit0 port change condition, bit1 any external interrupt input high
      s_next.irq_stat = s_next.irq_stat | {|ext_irq_in_o, any_mismatch};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg          <= '0;
         s_reg.latch    <= `BPCI_RST_LATCH;
         s_reg.dir      <= `BPCI_RST_DIR;
         s_reg.ictl1    <= `BPCI_RST_ICTL1;
         s_reg.ictl2    <= `BPCI_RST_ICTL2;
         s_reg.ictl3    <= `BPCI_RST_ICTL3;
         s_reg.segen1   <= `BPCI_RST_SEGEN;
         s_reg.segen3   <= `BPCI_RST_SEGEN;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule : bpci_port

//--- bpci_port_assertions.sv
// concurrent checks on the byte port block ports
module bpci_port_assertions (
   // clock, reset and bus handshake
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   // pins and overrides
   input wire logic [7:0] pin_i,
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe_o,
   input wire logic [7:0] pullup_en_o,
   input wire logic       lcd_seg_thirty_i,
   input wire logic       lcd_seg_nine_i,
   input wire logic [5:0] seg_sel_o,
   input wire logic       debug_mode_i,
   input wire logic       debug_serial_clock_o,
   // interrupt side
   input wire logic [3:0] ext_irq_in_o,
   input wire logic       port_change_irq_o,
   input wire logic       wake_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   a_bus_answer: assert property (s_req |=> s_ans) else $error("ack not a one cycle answer");
   a_pullup_output: assert property ((pullup_en_o & pin_oe_o) == 8'h00)
      else $error("pull-up on a driven pin");
   a_reset_pullups: assert property ($fell(rst_i) |-> pullup_en_o == 8'h00 && pin_oe_o == 8'h00)
      else $error("pull-ups or drivers on after reset");
   a_seg_thirty: assert property (seg_sel_o[0] |-> pin_oe_o[0] && pin_o[0] == lcd_seg_thirty_i)
      else $error("pin 0 not carrying its segment");
   a_seg_nine: assert property (seg_sel_o[2] |-> pin_oe_o[2] && pin_o[2] == lcd_seg_nine_i)
      else $error("pin 2 not carrying its segment");
   a_ext_irq_gate: assert property ((ext_irq_in_o & (~pin_i[3:0] | pin_oe_o[3:0])) == 4'h0)
      else $error("external request without a high input pin");
   a_debug_clock: assert property (debug_mode_i |-> debug_serial_clock_o == pin_i[6])
      else $error("debug clock not taken from pin 6");
   a_wake_follow: assert property ($rose(port_change_irq_o) |-> wake_o)
      else $error("change interrupt without wake");
endmodule : bpci_port_assertions

bind bpci_port bpci_port_assertions bpci_port_assertions_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .pin_i, .pin_o, .pin_oe_o, .pullup_en_o, .lcd_seg_thirty_i, .lcd_seg_nine_i, .seg_sel_o,
   .debug_mode_i, .debug_serial_clock_o, .ext_irq_in_o, .port_change_irq_o, .wake_o);

//--- bpci_pins_model.sv
// pad model: keypad switches, weak pull-ups and floating lines
module bpci_pins_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] pin_o,
   input  wire logic [7:0] pin_oe_o,
   input  wire logic [7:0] pullup_en_o,
   input  wire logic [7:0] key_i,
   input  wire logic [7:0] key_en_i,
   output logic      [7:0] pin_i
);
   logic [7:0] float_reg = 8'h55;
   // a released line without pull-up must not look stable
   always @(posedge clk_i) float_reg <= ~float_reg;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_o[i]) pin_i[i] = pin_o[i];
         else if (key_en_i[i]) pin_i[i] = key_i[i];
         else if (pullup_en_o[i]) pin_i[i] = 1'b1;
         else pin_i[i] = float_reg[i];
      end
   end
endmodule : bpci_pins_model

//--- bpci_port_tb.sv
// self-checking bench for the byte port block
`include "bpci_regs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module bpci_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mm = 0, seg = 0, dbg = 0;
   logic [5:0]  adr = 6'h00, seg_sel_o;
   logic [31:0] dat = 32'h0, rdat;
   logic [7:0]  key = 8'h00, key_en = 8'h00, q, pin_i, pin_o, pin_oe_o, pullup_en_o;
   logic        wb_ack_o, chg_irq, irq_o, dclk, wake, ddat;
   logic [3:0]  ext;
   int          err_count = 0, compares = 0, cycles = 0;
   bpci_port bpci_port_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o, .mem_to_mem_move_i(mm), .pin_i, .pin_o,
      .pin_oe_o, .pullup_en_o, .lcd_seg_thirty_i(seg), .lcd_seg_eight_i(seg), .lcd_seg_nine_i(seg),
      .lcd_seg_ten_i(seg), .lcd_seg_eleven_i(seg), .lcd_seg_twenty_nine_i(seg), .seg_sel_o,
      .debug_mode_i(dbg), .debug_serial_data_i(dbg), .debug_serial_data_oe_i(dbg),
      .debug_serial_clock_o(dclk), .debug_serial_data_o(ddat), .ext_irq_in_o(ext), .port_change_irq_o(chg_irq),
      .port_change_priority_o(), .wake_o(wake), .irq_o);
   bpci_pins_model bpci_pins_model_inst (.clk_i, .pin_o, .pin_oe_o, .pullup_en_o, .key_i(key),
      .key_en_i(key_en), .pin_i);
   initial forever #50 clk_i = ~clk_i;
   task automatic end_sim();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   // the whole run needs fewer than a hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {a, 2'b00};
      dat <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic t_reset();
      `CHK(pullup_en_o, 8'h00)
      wb(0, `BPCI_ADDR_ICTL2, 8'h00);
      `CHK(q, `BPCI_RST_ICTL2)
      wb(0, 4'hf, 8'h00);
      `CHK(q, 8'h00)
      $display("test t_reset done");
   endtask : t_reset
   task automatic t_drive();
      key_en <= 8'h0f;
      key    <= 8'h03;
      wb(1, `BPCI_ADDR_DIR, 8'h0f);
      wb(1, `BPCI_ADDR_PORT, 8'ha5);
      `CHK(pin_oe_o, 8'hf0)
      `CHK(pin_o[7:4], 4'ha)
      wb(0, `BPCI_ADDR_PORT, 8'h00);
      `CHK(q, 8'ha3)
      `CHK(ext, 4'h3)
      wb(1, `BPCI_ADDR_ICTL2, 8'h7f);
      `CHK(pullup_en_o, 8'h0f)
      wb(0, `BPCI_ADDR_LATCH, 8'h00);
      `CHK(q, 8'ha5)
      $display("test t_drive done");
   endtask : t_drive
   task automatic t_change();
      key_en <= 8'hff;
      key    <= 8'h00;
      wb(1, `BPCI_ADDR_DIR, 8'hff);
      wb(0, `BPCI_ADDR_PORT, 8'h00);
      wb(1, `BPCI_ADDR_IRQ_MASK, 8'h01);
      wb(1, `BPCI_ADDR_IRQ_STAT, 8'h03);
      `CHK(irq_o, 1'b0)
      wb(1, `BPCI_ADDR_ICTL1, 8'h00);
      key <= 8'h08;
      wb(0, `BPCI_ADDR_ICTL1, 8'h00);
      `CHK(q, 8'h00)
      key <= 8'h88;
      wb(0, `BPCI_ADDR_ICTL1, 8'h00);
      `CHK(q, 8'h01)
      wb(1, `BPCI_ADDR_ICTL1, 8'h08);
      wb(0, `BPCI_ADDR_ICTL1, 8'h00);
      `CHK(q, 8'h09)
      `CHK(chg_irq, 1'b1)
      `CHK(wake, 1'b1)
      `CHK(irq_o, 1'b1)
      mm <= 1'b1;
      wb(1, `BPCI_ADDR_PORT, 8'h00);
      mm <= 1'b0;
      wb(1, `BPCI_ADDR_ICTL1, 8'h08);
      wb(0, `BPCI_ADDR_ICTL1, 8'h00);
      `CHK(q, 8'h09)
      wb(0, `BPCI_ADDR_PORT, 8'h00);
      `CHK(q, 8'h88)
      wb(1, `BPCI_ADDR_ICTL1, 8'h08);
      wb(0, `BPCI_ADDR_ICTL1, 8'h00);
      `CHK(q, 8'h08)
      `CHK(chg_irq, 1'b0)
      wb(1, `BPCI_ADDR_IRQ_STAT, 8'h03);
      `CHK(irq_o, 1'b0)
      wb(1, `BPCI_ADDR_IRQ_MASK, 8'h02);
      `CHK(irq_o, 1'b1)
      $display("test t_change done");
   endtask : t_change
   task automatic t_seg();
      wb(1, `BPCI_ADDR_SEGEN3, 8'h40);
      wb(1, `BPCI_ADDR_SEGEN1, 8'h02);
      seg <= 1'b1;
      dbg <= 1'b1;
      key <= 8'hc8;
      @(posedge clk_i);
      `CHK(pin_o[0], 1'b1)
      `CHK(pin_o[2], 1'b1)
      `CHK(seg_sel_o, 6'h05)
      `CHK(dclk, 1'b1)
      `CHK(pin_oe_o[7], 1'b1)
      `CHK(ddat, 1'b1)
      seg <= 1'b0;
      dbg <= 1'b0;
      wb(1, `BPCI_ADDR_SEGEN3, 8'h00);
      $display("test t_seg done");
   endtask : t_seg
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_drive();
      t_change();
      t_seg();
      end_sim();
   end
endmodule : bpci_port_tb
